// ### rtl/mic_pkg.sv
/*
  Shared constants and types of the multilevel interrupt controller.
  Assumes a single clock domain and an APB register port with 32-bit data.
*/
package mic_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] MIC_IDX_STATUS  = 8'h00;
  localparam logic [7:0] MIC_IDX_LASTVEC = 8'h01;
  localparam logic [7:0] MIC_IDX_CTRL    = 8'h02;
  localparam int         MIC_BYTES_PER_REG = 4;

  // Status field positions
  localparam int MIC_ST_NMI = 7;
  localparam int MIC_ST_HI  = 2;
  localparam int MIC_ST_MID = 1;
  localparam int MIC_ST_LO  = 0;

  // Control field positions
  localparam int MIC_CT_RR  = 7;
  localparam int MIC_CT_VTS = 6;
  localparam int MIC_CT_HI  = 2;
  localparam int MIC_CT_MID = 1;
  localparam int MIC_CT_LO  = 0;

  // Reset values
  localparam logic [7:0] MIC_RST_STATUS  = 8'h00;
  localparam logic [7:0] MIC_RST_LASTVEC = 8'h00;
  localparam logic [7:0] MIC_RST_CTRL    = 8'h00;

  // Writable bits of the control register (reserved bits stay zero)
  localparam logic [7:0] MIC_CTRL_WMASK  = 8'hc7;

  // Level code carried with each request
  typedef enum logic [1:0] {
    MIC_LVL_OFF = 2'b00,
    MIC_LVL_LO  = 2'b01,
    MIC_LVL_MID = 2'b10,
    MIC_LVL_HI  = 2'b11
  } mic_level_type;

  // APB answer phase
  typedef enum logic [0:0] {
    MIC_BUS_IDLE   = 1'b0,
    MIC_BUS_ANSWER = 1'b1
  } mic_bus_type;

  // Result of one arbitration search
  typedef struct packed {
    logic       hit;
    logic [7:0] vec;
  } mic_pick_type;

  // Vector presented to the CPU
  typedef struct packed {
    logic          valid;
    logic          nmi;
    mic_level_type level;
    logic [7:0]    vec;
  } mic_offer_type;

  // Whole state of the controller
  typedef struct packed {
    mic_bus_type   bus;
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
    logic [7:0]    status;
    logic [7:0]    lastVec;
    logic [7:0]    ctrl;
    mic_offer_type offer;
  } mic_state_type;

endpackage

// ### rtl/mic_controller.sv
/*
  Multilevel interrupt controller: level arbitration, executing-level tracking,
  optional round-robin for the low level, vector table placement, APB registers.
  Assumes request sources, CPU handshake and the protection unlock are on clk.
*/
`timescale 1ns/100ps
module mic_controller
  import mic_pkg::*;
#(
  parameter int NUM_VEC = 32,
  parameter int NUM_NMI = 2,
  parameter int ADDR_W  = 4
)(
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [ADDR_W-1:0]          paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic [NUM_VEC-1:0]         reqFlag,
  input  wire logic [NUM_VEC-1:0][1:0]    reqLevel,
  input  wire logic [NUM_NMI-1:0]         nmiReq,
  input  wire logic                       cfgUnlock,
  input  wire logic                       cpuAck,
  input  wire logic                       cpuReti,
  output logic                            irqValid,
  output logic                            irqNmi,
  output logic      [1:0]                 irqLevel,
  output logic      [7:0]                 irqVector,
  output logic                            vectorTableSel
);

  // Elaboration checks
  if (NUM_VEC < 1 || NUM_VEC > 256)
    $error("NUM_VEC must be 1 to 256");
  if (NUM_NMI < 1 || NUM_NMI > 256)
    $error("NUM_NMI must be 1 to 256");
  if (ADDR_W < 4)
    $error("ADDR_W must be at least 4");

  mic_state_type state_q;
  mic_state_type state_d;

  logic [NUM_VEC-1:0] loReq;
  logic [NUM_VEC-1:0] midReq;
  logic [NUM_VEC-1:0] hiReq;
  mic_pick_type       nmiPick;
  mic_pick_type       hiPick;
  mic_pick_type       midPick;
  mic_pick_type       loPick;
  logic               regHit;
  logic [7:0]         regIdx;
  logic [7:0]         regRead;
  logic               wrDone;

  // Split requests by level code
  for (genvar i = 0; i < NUM_VEC; i++)
  begin : g_split
    assign loReq[i]  = reqFlag[i] && (reqLevel[i] == MIC_LVL_LO);
    assign midReq[i] = reqFlag[i] && (reqLevel[i] == MIC_LVL_MID);
    assign hiReq[i]  = reqFlag[i] && (reqLevel[i] == MIC_LVL_HI);
  end

  // Lowest set index wins
  function automatic mic_pick_type pickStatic(input logic [255:0] req, input int n);
    mic_pick_type p;
    p = '0;
    for (int k = n - 1; k >= 0; k--)
    begin
      if (req[k])
      begin
        p.hit = 1'b1;
        p.vec = 8'(k);
      end
    end
    return p;
  endfunction

  // Search starts just after the recorded vector, which comes last
  function automatic mic_pick_type pickRound(input logic [255:0] req, input int n,
                                             input logic [7:0] last);
    mic_pick_type p;
    int           idx;
    p = '0;
    for (int j = n; j >= 1; j--)
    begin
      idx = (int'(last) + j) % n;
      if (req[idx])
      begin
        p.hit = 1'b1;
        p.vec = 8'(idx);
      end
    end
    return p;
  endfunction

  // Per-class winners; high, mid and NMI always static
  always_comb
  begin
    nmiPick = pickStatic(256'(nmiReq), NUM_NMI);
    hiPick  = pickStatic(256'(hiReq), NUM_VEC);
    midPick = pickStatic(256'(midReq), NUM_VEC);
    if (state_q.ctrl[MIC_CT_RR])
      loPick = pickRound(256'(loReq), NUM_VEC, state_q.lastVec);
    else
      loPick = pickStatic(256'(loReq), NUM_VEC);
  end

  // Register decode
  assign regIdx = 8'(paddr[ADDR_W-1:2]);
  assign regHit = (paddr[1:0] == 2'b00) && (regIdx <= MIC_IDX_CTRL);
  assign wrDone = psel && penable && pwrite && state_q.pready && !state_q.pslverr;

  // Read data, reserved bits zero
  always_comb
  begin
    case (regIdx)
      MIC_IDX_STATUS:  regRead = state_q.status;
      MIC_IDX_LASTVEC: regRead = state_q.lastVec;
      MIC_IDX_CTRL:    regRead = state_q.ctrl;
      default:         regRead = 8'h00;
    endcase
  end

  // Next state
  always_comb
  begin
    state_d = state_q;

    // APB: answer in the cycle after setup, zero extra waits
    state_d.pready = 1'b0;
    case (state_q.bus)
      MIC_BUS_IDLE:
      begin
        if (psel && !penable)
        begin
          state_d.bus     = MIC_BUS_ANSWER;
          state_d.pready  = 1'b1;
          state_d.pslverr = !regHit;
          state_d.prdata  = (pwrite || !regHit) ? 32'h0000_0000 : {24'h00_0000, regRead};
        end
      end
      MIC_BUS_ANSWER:
      begin
        state_d.bus     = MIC_BUS_IDLE;
        state_d.pslverr = 1'b0;
        state_d.prdata  = 32'h0000_0000;
      end
      default:
      begin
        state_d.bus = MIC_BUS_IDLE;
      end
    endcase

    // Register writes; status is read-only
    if (wrDone && regIdx == MIC_IDX_LASTVEC)
      state_d.lastVec = pwdata[7:0];
    if (wrDone && regIdx == MIC_IDX_CTRL)
    begin
      // Round-robin off leaves the recorded vector alone
      state_d.ctrl = (pwdata[7:0] & MIC_CTRL_WMASK & ~(8'h01 << MIC_CT_VTS))
                   | (state_q.ctrl & (8'h01 << MIC_CT_VTS));
      if (cfgUnlock)
        state_d.ctrl[MIC_CT_VTS] = pwdata[MIC_CT_VTS];
    end

    // Return unwinds the most recent active level
    if (cpuReti)
    begin
      if (state_q.status[MIC_ST_NMI])
        state_d.status[MIC_ST_NMI] = 1'b0;
      else if (state_q.status[MIC_ST_HI])
        state_d.status[MIC_ST_HI] = 1'b0;
      else if (state_q.status[MIC_ST_MID])
        state_d.status[MIC_ST_MID] = 1'b0;
      else
        state_d.status[MIC_ST_LO] = 1'b0;
    end

    // Acknowledge sets the level flag; set wins over a clear
    if (cpuAck && state_q.offer.valid)
    begin
      if (state_q.offer.nmi)
        state_d.status[MIC_ST_NMI] = 1'b1;
      else
      begin
        case (state_q.offer.level)
          MIC_LVL_HI:  state_d.status[MIC_ST_HI] = 1'b1;
          MIC_LVL_MID: state_d.status[MIC_ST_MID] = 1'b1;
          MIC_LVL_LO:
          begin
            state_d.status[MIC_ST_LO] = 1'b1;
            if (state_q.ctrl[MIC_CT_RR])
              state_d.lastVec = state_q.offer.vec;
          end
          default: state_d.status = state_d.status;
        endcase
      end
    end

    // Offer: NMI, then enabled levels above the executing one
    state_d.offer = '0;
    if (state_q.status[MIC_ST_NMI])
      state_d.offer = '0;
    else if (nmiPick.hit)
    begin
      state_d.offer.valid = 1'b1;
      state_d.offer.nmi   = 1'b1;
      state_d.offer.vec   = nmiPick.vec;
    end
    else if (hiPick.hit && state_q.ctrl[MIC_CT_HI] && !state_q.status[MIC_ST_HI])
    begin
      state_d.offer.valid = 1'b1;
      state_d.offer.level = MIC_LVL_HI;
      state_d.offer.vec   = hiPick.vec;
    end
    else if (midPick.hit && state_q.ctrl[MIC_CT_MID]
             && !(state_q.status[MIC_ST_HI] || state_q.status[MIC_ST_MID]))
    begin
      state_d.offer.valid = 1'b1;
      state_d.offer.level = MIC_LVL_MID;
      state_d.offer.vec   = midPick.vec;
    end
    else if (loPick.hit && state_q.ctrl[MIC_CT_LO] && (state_q.status[2:0] == 3'b000))
    begin
      state_d.offer.valid = 1'b1;
      state_d.offer.level = MIC_LVL_LO;
      state_d.offer.vec   = loPick.vec;
    end

    // Never present a stale offer right after its acknowledge
    if (cpuAck && state_q.offer.valid)
      state_d.offer = '0;
  end

  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q         <= '0;
      state_q.status  <= MIC_RST_STATUS;
      state_q.lastVec <= MIC_RST_LASTVEC;
      state_q.ctrl    <= MIC_RST_CTRL;
    end
    else
      state_q <= state_d;
  end

  // Outputs straight from flops
  assign prdata         = state_q.prdata;
  assign pready         = state_q.pready;
  assign pslverr        = state_q.pslverr;
  assign irqValid       = state_q.offer.valid;
  assign irqNmi         = state_q.offer.nmi;
  assign irqLevel       = state_q.offer.level;
  assign irqVector      = state_q.offer.vec;
  assign vectorTableSel = state_q.ctrl[MIC_CT_VTS];

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_nmiFlag;
    cpuAck && irqValid && irqNmi |=> state_q.status[MIC_ST_NMI];
  endproperty
  a_nmiFlag: assert property (p_nmiFlag) else $error("NMI flag not set on ack");

  property p_retiNmi;
    cpuReti && state_q.status[MIC_ST_NMI] && !cpuAck |=> !state_q.status[MIC_ST_NMI]
      && $stable(state_q.status[2:0]);
  endproperty
  a_retiNmi: assert property (p_retiNmi) else $error("Return did not unwind NMI only");

  property p_hiHeld;
    state_q.status[MIC_ST_HI] && !cpuReti |=> state_q.status[MIC_ST_HI];
  endproperty
  a_hiHeld: assert property (p_hiHeld) else $error("High flag lost without return");

  property p_nmiBlocks;
    state_q.status[MIC_ST_NMI] |=> !irqValid;
  endproperty
  a_nmiBlocks: assert property (p_nmiBlocks) else $error("Offer during NMI handler");

  property p_loGate;
    !state_q.ctrl[MIC_CT_LO] |=> !(irqValid && !irqNmi && irqLevel == MIC_LVL_LO);
  endproperty
  a_loGate: assert property (p_loGate) else $error("Low offer while disabled");

  property p_rrRecord;
    cpuAck && irqValid && !irqNmi && irqLevel == MIC_LVL_LO && state_q.ctrl[MIC_CT_RR]
      |=> state_q.lastVec == $past(irqVector);
  endproperty
  a_rrRecord: assert property (p_rrRecord) else $error("Low vector not recorded");

  property p_vtsProtect;
    $changed(vectorTableSel) |-> $past(cfgUnlock) && $past(wrDone);
  endproperty
  a_vtsProtect: assert property (p_vtsProtect) else $error("Table select changed unprotected");

  property p_reservedZero;
    pready && !pslverr |-> prdata[31:8] == 24'h00_0000 && state_q.ctrl[5:3] == 3'b000
      && state_q.status[6:3] == 4'h0;
  endproperty
  a_reservedZero: assert property (p_reservedZero) else $error("Reserved bits not zero");

  property p_aboveExec;
    irqValid && !irqNmi |-> $past(state_q.status[MIC_ST_NMI]) == 1'b0
      && !(irqLevel == MIC_LVL_LO && $past(state_q.status[MIC_ST_LO]));
  endproperty
  a_aboveExec: assert property (p_aboveExec) else $error("Offer not above executing level");

  property p_midHeld;
    state_q.status[MIC_ST_MID] && !cpuReti |=> state_q.status[MIC_ST_MID];
  endproperty
  a_midHeld: assert property (p_midHeld) else $error("Mid flag lost without return");

  property p_loHeld;
    state_q.status[MIC_ST_LO] && !cpuReti |=> state_q.status[MIC_ST_LO];
  endproperty
  a_loHeld: assert property (p_loHeld) else $error("Low flag lost without return");

  property p_hiGate;
    !state_q.ctrl[MIC_CT_HI] |=> !(irqValid && !irqNmi && irqLevel == MIC_LVL_HI);
  endproperty
  a_hiGate: assert property (p_hiGate) else $error("High offer while disabled");

  property p_midGate;
    !state_q.ctrl[MIC_CT_MID] |=> !(irqValid && !irqNmi && irqLevel == MIC_LVL_MID);
  endproperty
  a_midGate: assert property (p_midGate) else $error("Mid offer while disabled");

  property p_retiHigh;
    cpuReti && !cpuAck && !state_q.status[MIC_ST_NMI] && state_q.status[MIC_ST_HI]
      |=> !state_q.status[MIC_ST_HI] && $stable(state_q.status[1:0]);
  endproperty
  a_retiHigh: assert property (p_retiHigh) else $error("Return did not unwind high only");

  property p_rrKeep;
    wrDone && regIdx == MIC_IDX_CTRL && !cpuAck |=> $stable(state_q.lastVec);
  endproperty
  a_rrKeep: assert property (p_rrKeep) else $error("Control write disturbed recorded vector");

  property p_levelCode;
    irqValid && !irqNmi |-> irqLevel != MIC_LVL_OFF;
  endproperty
  a_levelCode: assert property (p_levelCode) else $error("Offer carries the off level code");

endmodule

// ### test/mic_cpu_model.sv
/*
  CPU side model of the interrupt controller: acknowledges offers and
  executes returns as one-cycle pulses.
  Assumes the offer outputs are registered on clk.
*/
`timescale 1ns/100ps
module mic_cpu_model
  import mic_pkg::*;
(
  input  wire logic clk,
  output logic      cpuAck,
  output logic      cpuReti
);

  // Idle handshake at time zero
  initial
  begin
    cpuAck  = 1'b0;
    cpuReti = 1'b0;
  end

  // Takes the standing offer, promptly or after a lag
  task automatic take(input int lag);
    repeat (lag) @(posedge clk);
    cpuAck <= 1'b1;
    @(posedge clk);
    cpuAck <= 1'b0;
  endtask

  // Return from the running handler
  task automatic ret();
    @(posedge clk);
    cpuReti <= 1'b1;
    @(posedge clk);
    cpuReti <= 1'b0;
  endtask

endmodule

// ### test/tb_multilevel_interrupt_controller.sv
/*
  Self-checking bench of the interrupt controller: APB register access,
  level arbitration, nesting, enables and round-robin order.
  Assumes the CPU model in mic_cpu_model and the defaults of the design.
*/
`timescale 1ns/100ps
module tb_multilevel_interrupt_controller
  import mic_pkg::*;
;
  logic             clk;
  logic             rst_n;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic [3:0]       paddr;
  logic [31:0]      pwdata;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic [31:0]      reqFlag;
  logic [31:0][1:0] reqLevel;
  logic [1:0]       nmiReq;
  logic             cfgUnlock;
  logic             cpuAck;
  logic             cpuReti;
  logic             irqValid;
  logic             irqNmi;
  logic [1:0]       irqLevel;
  logic [7:0]       irqVector;
  logic             vectorTableSel;
  logic [31:0]      rdv;
  logic             rde;
  int               errCount;
  int               checks;

  mic_controller dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reqFlag(reqFlag), .reqLevel(reqLevel), .nmiReq(nmiReq), .cfgUnlock(cfgUnlock),
    .cpuAck(cpuAck), .cpuReti(cpuReti), .irqValid(irqValid), .irqNmi(irqNmi),
    .irqLevel(irqLevel), .irqVector(irqVector), .vectorTableSel(vectorTableSel));

  mic_cpu_model cpu (.clk(clk), .cpuAck(cpuAck), .cpuReti(cpuReti));

  // Clock of 100 ns period
  always #50 clk = ~clk;

  // Verdict and end of run
  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", checks, errCount);
    if (errCount == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      errCount++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer, waits for pready under a bound
  task automatic apb(input logic wr, input logic [3:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      errCount++;
      close_out();
    end
  endtask

  // Register read with expected data and error flag
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input logic expErr);
    logic [31:0] d;
    logic        e;
    apb(1'b0, {idx[1:0], 2'b00}, 32'h0, d, e);
    chk(d, exp, "read data");
    chk({31'h0, e}, {31'h0, expErr}, "slave error");
  endtask

  // Register write
  task automatic wrc(input logic [7:0] idx, input logic [31:0] v);
    logic [31:0] d;
    logic        e;
    apb(1'b1, {idx[1:0], 2'b00}, v, d, e);
  endtask

  // Offer seen by the CPU once the pipeline settles
  task automatic offer(input logic v, input logic nmi, input logic [1:0] lvl, input logic [7:0] vec);
    repeat (4) @(posedge clk);
    chk({20'h0, v ? {irqNmi, irqLevel, irqVector} : 11'h0, irqValid}, {20'h0, nmi, lvl, vec, v}, "offer");
  endtask

  // Main sequence
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, cfgUnlock, nmiReq} = '0;
    reqFlag = '0;
    reqLevel = '0;
    errCount = 0;
    checks = 0;
    reqLevel[3] = MIC_LVL_LO;
    reqLevel[9] = MIC_LVL_LO;
    reqLevel[12] = MIC_LVL_LO;
    reqLevel[20] = MIC_LVL_MID;
    reqLevel[25] = MIC_LVL_HI;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdc(MIC_IDX_STATUS, {24'h0, MIC_RST_STATUS}, 1'b0);
    rdc(MIC_IDX_LASTVEC, {24'h0, MIC_RST_LASTVEC}, 1'b0);
    rdc(MIC_IDX_CTRL, {24'h0, MIC_RST_CTRL}, 1'b0);
    rdc(8'h03, 32'h0, 1'b1);
    // Misaligned write is refused and leaves control alone
    apb(1'b1, 4'h9, 32'h0000_0080, rdv, rde);
    chk({31'h0, rde}, 32'h1, "misaligned write error");
    rdc(MIC_IDX_CTRL, 32'h0, 1'b0);
    wrc(MIC_IDX_STATUS, 32'h87);
    rdc(MIC_IDX_STATUS, 32'h0, 1'b0);
    wrc(MIC_IDX_CTRL, 32'h47);
    rdc(MIC_IDX_CTRL, 32'h07, 1'b0);
    chk({31'h0, vectorTableSel}, 32'h0, "table select");
    cfgUnlock <= 1'b1;
    wrc(MIC_IDX_CTRL, 32'h47);
    cfgUnlock <= 1'b0;
    rdc(MIC_IDX_CTRL, 32'h47, 1'b0);
    chk({31'h0, vectorTableSel}, 32'h1, "table select");
    // Off level code is never offered, a live code is
    reqFlag <= 32'h0000_0020;
    offer(1'b0, 1'b0, 2'b00, 8'd0);
    reqLevel[5] <= MIC_LVL_HI;
    offer(1'b1, 1'b0, MIC_LVL_HI, 8'd5);
    reqLevel[5] <= MIC_LVL_OFF;
    // Nesting low, mid, high and NMI
    reqFlag <= 32'h0000_0208;
    offer(1'b1, 1'b0, MIC_LVL_LO, 8'd3);
    cpu.take(0);
    offer(1'b0, 1'b0, 2'b00, 8'd0);
    rdc(MIC_IDX_STATUS, 32'h01, 1'b0);
    reqFlag[20] <= 1'b1;
    offer(1'b1, 1'b0, MIC_LVL_MID, 8'd20);
    cpu.take(2);
    rdc(MIC_IDX_STATUS, 32'h03, 1'b0);
    reqFlag[25] <= 1'b1;
    offer(1'b1, 1'b0, MIC_LVL_HI, 8'd25);
    cpu.take(0);
    nmiReq <= 2'b11;
    offer(1'b1, 1'b1, 2'b00, 8'd0);
    cpu.take(0);
    nmiReq <= 2'b10;
    offer(1'b0, 1'b0, 2'b00, 8'd0);
    rdc(MIC_IDX_STATUS, 32'h87, 1'b0);
    nmiReq <= 2'b00;
    reqFlag <= 32'h0000_0208;
    cpu.ret();
    rdc(MIC_IDX_STATUS, 32'h07, 1'b0);
    cpu.ret();
    rdc(MIC_IDX_STATUS, 32'h03, 1'b0);
    cpu.ret();
    rdc(MIC_IDX_STATUS, 32'h01, 1'b0);
    cpu.ret();
    rdc(MIC_IDX_STATUS, 32'h00, 1'b0);
    // Level enables
    offer(1'b1, 1'b0, MIC_LVL_LO, 8'd3);
    wrc(MIC_IDX_CTRL, 32'h06);
    @(posedge clk);
    chk({31'h0, irqValid}, 32'h1, "offer one cycle after disable");
    @(posedge clk);
    chk({31'h0, irqValid}, 32'h0, "offer after disable");
    reqFlag[25] <= 1'b1;
    offer(1'b1, 1'b0, MIC_LVL_HI, 8'd25);
    wrc(MIC_IDX_CTRL, 32'h02);
    offer(1'b0, 1'b0, 2'b00, 8'd0);
    reqFlag <= 32'h0010_0208;
    offer(1'b1, 1'b0, MIC_LVL_MID, 8'd20);
    wrc(MIC_IDX_CTRL, 32'h00);
    offer(1'b0, 1'b0, 2'b00, 8'd0);
    // Round-robin among low requests 3, 9, 12
    reqFlag <= 32'h0000_1208;
    wrc(MIC_IDX_CTRL, 32'h81);
    offer(1'b1, 1'b0, MIC_LVL_LO, 8'd3);
    cpu.take(0);
    rdc(MIC_IDX_LASTVEC, 32'd3, 1'b0);
    cpu.ret();
    offer(1'b1, 1'b0, MIC_LVL_LO, 8'd9);
    cpu.take(1);
    cpu.ret();
    offer(1'b1, 1'b0, MIC_LVL_LO, 8'd12);
    wrc(MIC_IDX_LASTVEC, 32'd12);
    offer(1'b1, 1'b0, MIC_LVL_LO, 8'd3);
    wrc(MIC_IDX_LASTVEC, 32'd3);
    offer(1'b1, 1'b0, MIC_LVL_LO, 8'd9);
    wrc(MIC_IDX_CTRL, 32'h01);
    rdc(MIC_IDX_LASTVEC, 32'd3, 1'b0);
    offer(1'b1, 1'b0, MIC_LVL_LO, 8'd3);
    close_out();
  end

endmodule
